// file: hdl/wdfp_cfg.svh
// register offsets, field positions, reset values and timing figures
// for the watchdog and programmable-frequency control slice
`ifndef WDFP_CFG_SVH
`define WDFP_CFG_SVH

`define WDFP_OFS_WD_CTRL 8'h0A
`define WDFP_OFS_MULT_LO 8'h0B
`define WDFP_OFS_MULT_HI_DIV 8'h0C
`define WDFP_OFS_SRC_LO 8'h0D
`define WDFP_OFS_MISC 8'h0E

`define WDFP_WD_ON_BIT 0
`define WDFP_CODE_LSB 1
`define WDFP_CODE_MSB 3
`define WDFP_FLAG_BIT 4
`define WDFP_TICK_BIT 5
`define WDFP_ACTION_BIT 6
`define WDFP_RECSEL_BIT 7

`define WDFP_MISC_REC8_BIT 0
`define WDFP_MISC_DRIVE_BIT 1
`define WDFP_MISC_OVR_BIT 5
`define WDFP_MISC_SWRST_BIT 6
`define WDFP_MISC_SRC8_BIT 7
`define WDFP_HI_MULT8_BIT 7
`define WDFP_DIV_MSB 6
`define WDFP_MISC_WR_MASK 8'hF3

`define WDFP_WD_CTRL_RST 8'h20
`define WDFP_MISC_RST 8'h02
`define WDFP_BYTE_ZERO 8'h00

`define WDFP_CLK_PERIOD_NS 5
`define WDFP_TICK_SHORT_MS 294
`define WDFP_TICK_LONG_MS 2340
`define WDFP_NS_PER_MS 1000000
`define WDFP_RESET_PULSE_CYC 16

`endif

// file: hdl/wdfp_pkg.sv
// types shared by the watchdog and frequency control slice
package wdfp_pkg;

  typedef enum logic [1:0] {
    WDFP_RST_IDLE = 2'b00,
    WDFP_RST_ARMED = 2'b01,
    WDFP_RST_PULSE = 2'b10
  } wdfp_rst_state_t;

  typedef struct packed {
    logic recoverySel;
    logic actionSel;
    logic tickUnit;
    logic timeoutFlag;
    logic [2:0] timeoutCountCode;
    logic watchdogOn;
  } wdfp_wd_ctrl_t;

  typedef struct packed {
    logic [8:0] coreMultiplier;
    logic [6:0] coreDivider;
    logic [3:0] freqCode;
    logic progActive;
  } wdfp_freq_t;

endpackage

// file: hdl/wdfp_tick_timer.sv
// watchdog period counter: whole tick units, expiry after a count of ticks
// assumes tickLen is at least one and stable while running
`timescale 1ns/100ps
`default_nettype none
module wdfp_tick_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic restart,
  input wire logic [31:0] tickLen,
  input wire logic [2:0] ticks,
  output logic expire
);
  logic [31:0] cyc_reg;
  logic [2:0] tickCnt_reg;
  logic tickEnd;
  logic lastTick;

  assign tickEnd = (cyc_reg == tickLen - 32'h00000001);
  assign lastTick = (tickCnt_reg == ticks - 3'h1);

  always_ff @(posedge clk)
  begin
    if (!nrst || restart || !run || ticks == 3'h0)
    begin
      cyc_reg <= 32'h00000000;
      tickCnt_reg <= 3'h0;
    end
    else if (tickEnd)
    begin
      cyc_reg <= 32'h00000000;
      tickCnt_reg <= lastTick ? 3'h0 : tickCnt_reg + 3'h1; // RL18
    end
    else
    begin
      cyc_reg <= cyc_reg + 32'h00000001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      expire <= 1'b0;
    else
      expire <= run && !restart && ticks != 3'h0 && tickEnd && lastTick; // RL5
  end
endmodule // wdfp_tick_timer
`default_nettype wire

// file: hdl/wdfp_regs.sv
// watchdog, recovery and programmable-frequency control registers
// assumes a serial bus engine giving byte writes and an end-of-write pulse
//
// Notes on behaviour
// (RL1) reboot restores strap frequency, or the 9-bit recovery multiplier, by select bit
// (RL2) expiry pulses reset; action 0 also reloads recovery frequency, 1 reset only
// (RL3) tick unit 294 ms or 2.34 s; resets to the long unit
// (RL4) expiry sets timeout flag; clearing the timeout code clears it
// (RL5) timeout is code times tick unit; code zero reserved, never expires
// (RL6) setting enable loads the period and starts; clearing disables
// (RL7) programmable mode uses 9-bit multiplier and 7-bit divider for the core clock
// (RL8) clock ratio from latched strap code, or soft code when overriding
// (RL9) multiplier low byte, then multiplier bit 8 above 7-bit divider
// (RL10) 9-bit serial reference multiplier split across two bytes, resets zero
// (RL11) software reset pulses only after the setting write transaction ends
// (RL12) software reset bit self clears after the reset pulse
// (RL13) system must strap the reset output on before relying on software reset
// (RL14) frequency from strap pins, or soft code when override set; resets zero
// (RL15) free-running bus clock drive 2x when 0, 1x when 1; resets to 1
// (RL16) programmable core frequency enable on when 1, resets off
// (RL17) lockup recovery: auto, manual multiplier, strap settings, or reset only
// (RL18) watchdog counts whole ticks from enable, expires if code not cleared
`timescale 1ns/100ps
`default_nettype none
`include "wdfp_cfg.svh"
module wdfp_regs #(
  parameter int unsigned TICK_SHORT_CYC =
    32'(64'(`WDFP_TICK_SHORT_MS) * `WDFP_NS_PER_MS / `WDFP_CLK_PERIOD_NS),
  parameter int unsigned TICK_LONG_CYC =
    32'(64'(`WDFP_TICK_LONG_MS) * `WDFP_NS_PER_MS / `WDFP_CLK_PERIOD_NS)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic xferDone,
  input wire logic powerGoodInN,
  input wire logic [4:0] strapFreqPins,
  input wire logic resetStrapPin,
  input wire logic [3:0] softFreqCode,
  input wire logic coreProgFreqOn,
  input wire logic autoRecoveryOn,
  input wire logic [7:0] recoveryMultLow,
  output wdfp_pkg::wdfp_freq_t freqOut,
  output logic [8:0] serialRefMultiplier,
  output logic [4:0] strapFreqCode,
  output logic freeRunBusClockWeak,
  output logic systemResetOutN
);
  wdfp_pkg::wdfp_wd_ctrl_t wd_reg;
  wdfp_pkg::wdfp_rst_state_t rstState_reg;
  logic [7:0] multLo_reg;
  logic [7:0] multHiDiv_reg;
  logic [7:0] srcLo_reg;
  logic [7:0] misc_reg;
  logic [8:0] autoMult_reg;
  logic hwFallback_reg;
  logic pgPrev_reg;
  logic resetOutOn_reg;
  logic [4:0] pulseCnt_reg;
  logic progPrev_reg;
  logic expire;
  logic wrWd;
  logic wrMisc;
  logic kick;
  logic pulseDone;
  logic [8:0] recoveryMult;

  assign wrWd = regWrite && regAddr == `WDFP_OFS_WD_CTRL;
  assign wrMisc = regWrite && regAddr == `WDFP_OFS_MISC;
  assign recoveryMult = {misc_reg[`WDFP_MISC_REC8_BIT], recoveryMultLow};
  // enable rising or a new code reloads the period
  assign kick = wrWd && (regWdata[`WDFP_WD_ON_BIT] && !wd_reg.watchdogOn
    || regWdata[`WDFP_CODE_MSB:`WDFP_CODE_LSB] != wd_reg.timeoutCountCode); // RL6
  assign pulseDone = rstState_reg == wdfp_pkg::WDFP_RST_PULSE
    && pulseCnt_reg == 5'(`WDFP_RESET_PULSE_CYC - 1);

  wdfp_tick_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .run(wd_reg.watchdogOn),
    .restart(kick),
    .tickLen(wd_reg.tickUnit ? TICK_LONG_CYC : TICK_SHORT_CYC), // RL3
    .ticks(wd_reg.timeoutCountCode),
    .expire(expire)
  );

  // watchdog control byte
  always_ff @(posedge clk)
  begin
    if (!nrst)
      wd_reg <= `WDFP_WD_CTRL_RST; // RL3
    else
    begin
      if (wrWd)
      begin
        wd_reg.recoverySel <= regWdata[`WDFP_RECSEL_BIT];
        wd_reg.actionSel <= regWdata[`WDFP_ACTION_BIT];
        wd_reg.tickUnit <= regWdata[`WDFP_TICK_BIT];
        wd_reg.timeoutCountCode <= regWdata[`WDFP_CODE_MSB:`WDFP_CODE_LSB];
        wd_reg.watchdogOn <= regWdata[`WDFP_WD_ON_BIT]; // RL6
      end
      // expiry wins over a clear in the same cycle
      if (expire)
        wd_reg.timeoutFlag <= 1'b1; // RL4
      else if (wrWd && regWdata[`WDFP_CODE_MSB:`WDFP_CODE_LSB] == 3'h0)
        wd_reg.timeoutFlag <= 1'b0; // RL4
    end
  end

  // frequency bytes, with recovery reload on expiry
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      multLo_reg <= `WDFP_BYTE_ZERO;
      multHiDiv_reg <= `WDFP_BYTE_ZERO;
      srcLo_reg <= `WDFP_BYTE_ZERO; // RL10
      hwFallback_reg <= 1'b0;
    end
    else if (expire && !wd_reg.actionSel) // RL2
    begin
      if (autoRecoveryOn)
        {multHiDiv_reg[`WDFP_HI_MULT8_BIT], multLo_reg} <= autoMult_reg; // RL17
      else if (wd_reg.recoverySel)
        {multHiDiv_reg[`WDFP_HI_MULT8_BIT], multLo_reg} <= recoveryMult; // RL1
      else
        hwFallback_reg <= 1'b1; // RL1
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        `WDFP_OFS_MULT_LO:
        begin
          multLo_reg <= regWdata; // RL9
          hwFallback_reg <= 1'b0;
        end
        `WDFP_OFS_MULT_HI_DIV:
        begin
          multHiDiv_reg <= regWdata; // RL9
          hwFallback_reg <= 1'b0;
        end
        `WDFP_OFS_SRC_LO: srcLo_reg <= regWdata; // RL10
        default: ;
      endcase
    end
  end

  // last multiplier in force when programmable mode was turned on
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      autoMult_reg <= 9'h000;
      progPrev_reg <= 1'b0;
    end
    else
    begin
      progPrev_reg <= coreProgFreqOn;
      if (coreProgFreqOn && !progPrev_reg)
        autoMult_reg <= {multHiDiv_reg[`WDFP_HI_MULT8_BIT], multLo_reg}; // RL17
    end
  end

  // misc byte; software reset bit held by hardware until pulse done
  always_ff @(posedge clk)
  begin
    if (!nrst)
      misc_reg <= `WDFP_MISC_RST; // RL15
    else
    begin
      if (wrMisc)
      begin
        misc_reg <= regWdata & `WDFP_MISC_WR_MASK;
        if (rstState_reg != wdfp_pkg::WDFP_RST_IDLE)
          misc_reg[`WDFP_MISC_SWRST_BIT] <= 1'b1;
      end
      if (expire && !wd_reg.actionSel && !autoRecoveryOn && !wd_reg.recoverySel)
        misc_reg[`WDFP_MISC_OVR_BIT] <= 1'b0; // RL1
      if (pulseDone)
        misc_reg[`WDFP_MISC_SWRST_BIT] <= 1'b0; // RL12
    end
  end

  // reset pulse sequencer for software and watchdog resets
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rstState_reg <= wdfp_pkg::WDFP_RST_IDLE;
      pulseCnt_reg <= 5'h00;
    end
    else
    begin
      unique case (rstState_reg)
        wdfp_pkg::WDFP_RST_IDLE:
        begin
          pulseCnt_reg <= 5'h00;
          if (expire)
            rstState_reg <= wdfp_pkg::WDFP_RST_PULSE; // RL2
          else if (wrMisc && regWdata[`WDFP_MISC_SWRST_BIT])
            rstState_reg <= wdfp_pkg::WDFP_RST_ARMED;
        end
        wdfp_pkg::WDFP_RST_ARMED:
          if (xferDone)
            rstState_reg <= wdfp_pkg::WDFP_RST_PULSE; // RL11
        wdfp_pkg::WDFP_RST_PULSE:
        begin
          pulseCnt_reg <= pulseCnt_reg + 5'h01;
          if (pulseDone)
            rstState_reg <= wdfp_pkg::WDFP_RST_IDLE;
        end
        default: rstState_reg <= wdfp_pkg::WDFP_RST_IDLE;
      endcase
    end
  end

  // straps caught on the falling edge of power good
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pgPrev_reg <= 1'b1;
      strapFreqCode <= 5'h00;
      resetOutOn_reg <= 1'b0;
    end
    else
    begin
      pgPrev_reg <= powerGoodInN;
      if (pgPrev_reg && !powerGoodInN)
      begin
        strapFreqCode <= strapFreqPins;
        resetOutOn_reg <= resetStrapPin; // RL13
      end
    end
  end

  // outputs toward the synthesiser
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      freqOut <= '0;
      serialRefMultiplier <= 9'h000;
      freeRunBusClockWeak <= 1'b1;
      systemResetOutN <= 1'b1;
    end
    else
    begin
      freqOut.progActive <= coreProgFreqOn && !hwFallback_reg; // RL16
      freqOut.coreMultiplier <= {multHiDiv_reg[`WDFP_HI_MULT8_BIT], multLo_reg}; // RL7
      freqOut.coreDivider <= multHiDiv_reg[`WDFP_DIV_MSB:0]; // RL7
      freqOut.freqCode <= misc_reg[`WDFP_MISC_OVR_BIT] ? softFreqCode
        : strapFreqCode[3:0]; // RL8 RL14
      serialRefMultiplier <= {misc_reg[`WDFP_MISC_SRC8_BIT], srcLo_reg}; // RL10
      freeRunBusClockWeak <= misc_reg[`WDFP_MISC_DRIVE_BIT]; // RL15
      systemResetOutN <= !(rstState_reg == wdfp_pkg::WDFP_RST_PULSE && resetOutOn_reg);
    end
  end

  // read data registered one cycle after the address
  always_ff @(posedge clk)
  begin
    if (!nrst)
      regRdata <= `WDFP_BYTE_ZERO;
    else
    begin
      unique case (regAddr)
        `WDFP_OFS_WD_CTRL: regRdata <= wd_reg;
        `WDFP_OFS_MULT_LO: regRdata <= multLo_reg;
        `WDFP_OFS_MULT_HI_DIV: regRdata <= multHiDiv_reg;
        `WDFP_OFS_SRC_LO: regRdata <= srcLo_reg;
        `WDFP_OFS_MISC: regRdata <= misc_reg;
        default: regRdata <= `WDFP_BYTE_ZERO;
      endcase
    end
  end
endmodule // wdfp_regs
`default_nettype wire

// file: tb/wdfp_regs_properties.sv
// assertions on the register port and reset pin of wdfp_regs
// bound from the testbench top; one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module wdfp_regs_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic xferDone,
  input wire logic powerGoodInN,
  input wire logic [4:0] strapFreqPins,
  input wire logic [8:0] serialRefMultiplier,
  input wire logic [4:0] strapFreqCode,
  input wire logic freeRunBusClockWeak,
  input wire logic systemResetOutN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic armed_reg;
  logic miscWr;
  logic drvBit;
  assign miscWr = regWrite && regAddr == 8'h0E;
  assign drvBit = regWdata[1];
  // soft reset requested, write transaction still open
  always_ff @(posedge clk)
    if (!nrst || xferDone)
      armed_reg <= 1'b0;
    else if (miscWr && regWdata[6])
      armed_reg <= 1'b1;
  pulse_width_a: assert property ($fell(systemResetOutN) |->
    (!systemResetOutN)[*8] ##1 (!systemResetOutN)[*8] ##1 systemResetOutN)
    else $error("reset pulse width wrong");
  swrst_wait_a: assert property (armed_reg |-> systemResetOutN)
    else $error("reset before write end");
  swrst_pulse_a: assert property (armed_reg && xferDone |-> ##2 !systemResetOutN)
    else $error("soft reset not pulsed");
  swrst_clear_a: assert property ($rose(systemResetOutN) ##0 (regAddr == 8'h0E)[*4]
    |-> !regRdata[6]) else $error("soft reset bit stuck");
  strap_latch_a: assert property ($fell(powerGoodInN) |-> ##3
    strapFreqCode == $past(strapFreqPins, 3)) else $error("straps not latched");
  drive_bit_a: assert property (miscWr ##1 !regWrite |=>
    freeRunBusClockWeak == $past(drvBit, 2)) else $error("drive bit not taken");
  src_low_a: assert property (regWrite && regAddr == 8'h0D ##1 !regWrite |=>
    serialRefMultiplier[7:0] == $past(regWdata, 2)) else $error("src byte not taken");
  unmapped_zero_a: assert property (!(regAddr inside {[8'h0A:8'h0E]}) |=>
    regRdata == 8'h00) else $error("unmapped read not zero");
  flag_clear_a: assert property (regWrite && regAddr == 8'h0A && regWdata[3:1] == 3'h0
    ##1 (regAddr == 8'h0A)[*2] |-> !regRdata[4]) else $error("flag not cleared");
  cover property ($fell(systemResetOutN));
  cover property (armed_reg && xferDone);
  cover property ($fell(powerGoodInN));
endmodule // wdfp_regs_properties
`default_nettype wire

// file: tb/wdfp_host_model.sv
// serial bus host stand-in: byte writes, end-of-write pulse, reads
// drives the register port of wdfp_regs just after rising edges
`timescale 1ns/100ps
`default_nettype none
module wdfp_host_model (
  input wire logic clk,
  input wire logic [7:0] regRdata,
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output logic xferDone
);
  initial
  begin
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    xferDone = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regWdata <= ~d; // released data shows no stale byte
  endtask
  task automatic stop();
    @(posedge clk);
    xferDone <= 1'b1;
    @(posedge clk);
    xferDone <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    @(posedge clk);
    #1 d = regRdata;
  endtask
endmodule // wdfp_host_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for wdfp_regs with the host stand-in
// assumes package, design, host model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic powerGoodInN = 1'b1;
  logic [4:0] strapFreqPins = 5'h00;
  logic resetStrapPin = 1'b0;
  logic [3:0] softFreqCode = 4'h0;
  logic coreProgFreqOn = 1'b0;
  logic autoRecoveryOn = 1'b0;
  logic [7:0] recoveryMultLow = 8'h00;
  logic regWrite, xferDone, freeRunBusClockWeak, systemResetOutN;
  logic [7:0] regAddr, regWdata, regRdata, rv;
  logic [8:0] serialRefMultiplier;
  logic [4:0] strapFreqCode;
  wdfp_pkg::wdfp_freq_t freqOut;
  int badCount = 0;
  int cmpCount = 0;
  int n;
  always #2.5 clk = ~clk;
  wdfp_regs #(.TICK_SHORT_CYC(10), .TICK_LONG_CYC(20)) dut (.clk, .nrst, .regWrite,
    .regAddr, .regWdata, .regRdata, .xferDone, .powerGoodInN, .strapFreqPins,
    .resetStrapPin, .softFreqCode, .coreProgFreqOn, .autoRecoveryOn, .recoveryMultLow,
    .freqOut, .serialRefMultiplier, .strapFreqCode, .freeRunBusClockWeak,
    .systemResetOutN);
  wdfp_host_model host (.clk, .regRdata, .regWrite, .regAddr, .regWdata, .xferDone);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic waitFall();
    n = 0;
    while (systemResetOutN !== 1'b0 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic expire(input logic [7:0] ctl, input int lo, input int hi);
    host.wr(8'h0A, ctl);
    waitFall();
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask
  task automatic tReg();
    logic [7:0] exp [6];
    exp = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      host.rd(8'h0A + 8'(i), rv);
      chk(16'(rv), 16'(exp[i]));
    end
    chk(16'({freeRunBusClockWeak, systemResetOutN, freqOut.progActive}), 16'h0006);
    $display("reset values done");
  endtask
  task automatic tStrap();
    @(posedge clk);
    strapFreqPins <= 5'h15;
    resetStrapPin <= 1'b1;
    repeat (4) @(posedge clk);
    powerGoodInN <= 1'b0;
    repeat (5) @(posedge clk);
    chk(16'(strapFreqCode), 16'h0015);
    chk(16'(freqOut.freqCode), 16'h0005);
    softFreqCode <= 4'h9;
    host.wr(8'h0E, 8'hAC);
    host.wr(8'h0D, 8'h5A);
    host.rd(8'h0E, rv);
    chk(16'(rv), 16'h00A0);
    chk(16'({freeRunBusClockWeak, freqOut.freqCode, serialRefMultiplier}), 16'h135A);
    host.wr(8'h0E, 8'h02);
    $display("strap and misc done");
  endtask
  task automatic tCore();
    coreProgFreqOn <= 1'b1;
    host.wr(8'h0B, 8'hA5);
    host.wr(8'h0C, 8'hB3);
    host.rd(8'h0C, rv);
    chk(16'(rv), 16'h00B3);
    chk(16'({freqOut.coreMultiplier, freqOut.coreDivider}), 16'hD2B3);
    chk(16'(freqOut.progActive), 16'h0001);
    $display("core frequency done");
  endtask
  task automatic tSoft();
    host.wr(8'h0E, 8'h42);
    repeat (6) @(posedge clk);
    chk(16'(systemResetOutN), 16'h0001);
    host.stop();
    waitFall();
    chk(16'(n >= 1 && n <= 3), 16'h0001);
    repeat (20) @(posedge clk);
    host.rd(8'h0E, rv);
    chk(16'(rv), 16'h0002);
    $display("soft reset done");
  endtask
  task automatic tWatch();
    expire(8'h47, 29, 35);
    chk(16'(freqOut.coreMultiplier), 16'h01A5);
    host.rd(8'h0A, rv);
    chk(16'(rv), 16'h0057);
    host.wr(8'h0A, 8'h41);
    host.rd(8'h0A, rv);
    chk(16'(rv), 16'h0041);
    repeat (80) @(posedge clk);
    chk(16'(systemResetOutN), 16'h0001);
    recoveryMultLow <= 8'h3C;
    host.wr(8'h0E, 8'h03);
    expire(8'hA5, 39, 45);
    chk(16'(freqOut.coreMultiplier), 16'h013C);
    host.wr(8'h0A, 8'h00);
    repeat (60) @(posedge clk);
    chk(16'(systemResetOutN), 16'h0001);
    expire(8'h03, 9, 15);
    chk(16'(freqOut.progActive), 16'h0000);
    host.wr(8'h0A, 8'h00);
    $display("watchdog done");
  endtask
  task automatic tAuto();
    // let the previous reset pulse run out first
    repeat (20) @(posedge clk);
    coreProgFreqOn <= 1'b0;
    host.wr(8'h0B, 8'h66);
    coreProgFreqOn <= 1'b1;
    host.wr(8'h0B, 8'h11);
    autoRecoveryOn <= 1'b1;
    expire(8'h03, 9, 15);
    chk(16'(freqOut.coreMultiplier), 16'h0166);
    chk(16'(freqOut.progActive), 16'h0001);
    autoRecoveryOn <= 1'b0;
    host.wr(8'h0A, 8'h00);
    $display("auto recovery done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    tReg();
    tStrap();
    tCore();
    tSoft();
    tWatch();
    tAuto();
    closeOut();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    badCount++;
    closeOut();
  end
endmodule // tb
bind wdfp_regs wdfp_regs_properties chk (.clk, .nrst, .regWrite, .regAddr, .regWdata,
  .regRdata, .xferDone, .powerGoodInN, .strapFreqPins, .serialRefMultiplier,
  .strapFreqCode, .freeRunBusClockWeak, .systemResetOutN);
`default_nettype wire
